//--- design/apfs_aux_pin_function_select.sv
// Behaviour
// - There are eleven auxiliary pins, each with its own function select.
// - Each pin function comes from configuration bits loaded from memory.
// - Each pin has optional inversion and its own drive strength setting.
// - The driver-enable option outputs the RS485 transmitter enable.
// - Driver enable is high only while a character shifts out.
// - The power-enable option gives an active-low power control signal.
// - Power enable is high during suspend and low in normal operation.
// - The transmit LED option pulses low when data is transmitted.
// - The receive LED option pulses low when data is received.
// - The combined LED option pulses low on transmit or receive.
// - The suspend option goes low as the device enters suspend.
// - Clock options drive a continuous 31.25, 15.625 or 7.8125 MHz clock (250 MHz divided by 8, 16 or 32).
// - The unused option releases the pin and it reads high by pull-up.
// - Constant options drive a fixed high or a fixed low.
// - Pins may be software GPIO during UART use, up to four of them.
`timescale 1ns/10ps
module apfs_aux_pin_function_select
    import apfs_pkg::*;
(
    // Clock and reset.
    input  wire logic                       mclk_in,
    input  wire logic                       rst_b_in,
    // Configuration loaded from non-volatile memory.
    input  wire logic                       cfg_valid_in,
    input  wire logic [PIN_CNT*FUNC_W-1:0]  cfg_func_in,
    input  wire logic [PIN_CNT-1:0]         cfg_invert_in,
    input  wire logic [PIN_CNT*DRIVE_W-1:0] cfg_drive_in,
    // Status from the serial controller and the USB engine.
    input  wire logic                       tx_shifting_in,
    input  wire logic                       tx_data_in,
    input  wire logic                       rx_data_in,
    input  wire logic                       usb_suspend_in,
    // Software GPIO.
    input  wire logic [PIN_CNT-1:0]         gpio_out_val_in,
    input  wire logic [PIN_CNT-1:0]         gpio_dir_out_in,
    output logic      [PIN_CNT-1:0]         gpio_in_val_out,
    // Auxiliary control bus pins.
    input  wire logic [PIN_CNT-1:0]         aux_control_bus_in,
    output logic      [PIN_CNT-1:0]         aux_control_bus_out,
    output logic      [PIN_CNT-1:0]         aux_control_bus_oe_n_out,
    output logic      [PIN_CNT-1:0]         aux_pullup_en_out,
    output logic      [PIN_CNT*DRIVE_W-1:0] aux_drive_out
);

    // ========================================================================
    // Configuration capture.
    // ========================================================================
    logic [PIN_CNT*FUNC_W-1:0]  func_ff;
    logic [PIN_CNT*FUNC_W-1:0]  nxt_func;
    logic [PIN_CNT-1:0]         inv_ff;
    logic [PIN_CNT-1:0]         nxt_inv;
    logic [PIN_CNT*DRIVE_W-1:0] drv_ff;
    logic [PIN_CNT*DRIVE_W-1:0] nxt_drv;

    always_comb begin
        nxt_func = func_ff;
        nxt_inv  = inv_ff;
        nxt_drv  = drv_ff;
        if (cfg_valid_in) begin
            nxt_func = cfg_func_in;
            nxt_inv  = cfg_invert_in;
            nxt_drv  = cfg_drive_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            func_ff <= '0;
            inv_ff  <= '0;
            drv_ff  <= '0;
        end else begin
            func_ff <= nxt_func;
            inv_ff  <= nxt_inv;
            drv_ff  <= nxt_drv;
        end
    end

    // ========================================================================
    // Clock dividers.
    // ========================================================================
    logic [DIV_W-1:0] div_cnt_ff [3];
    logic [DIV_W-1:0] nxt_div_cnt [3];
    logic [2:0]       div_clk_ff;
    logic [2:0]       nxt_div_clk;
    logic [DIV_W-1:0] div_half [3];

    assign div_half[0] = DIV30_HALF;
    assign div_half[1] = DIV15_HALF;
    assign div_half[2] = DIV7P5_HALF;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_div_cnt[i] = div_cnt_ff[i] + 1'b1;
            nxt_div_clk[i] = div_clk_ff[i];
            if (div_cnt_ff[i] >= div_half[i] - 1'b1) begin
                nxt_div_cnt[i] = '0;
                nxt_div_clk[i] = ~div_clk_ff[i];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < 3; i++) begin
                div_cnt_ff[i] <= '0;
            end
            div_clk_ff <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                div_cnt_ff[i] <= nxt_div_cnt[i];
            end
            div_clk_ff <= nxt_div_clk;
        end
    end

    // ========================================================================
    // Activity LED stretchers.
    // ========================================================================
    logic tx_led_n;
    logic rx_led_n;
    logic any_led_n;

    apfs_led_stretch u_tx_led (
        .mclk_in   (mclk_in),
        .rst_b_in  (rst_b_in),
        .event_in  (tx_data_in),
        .led_n_out (tx_led_n)
    );

    apfs_led_stretch u_rx_led (
        .mclk_in   (mclk_in),
        .rst_b_in  (rst_b_in),
        .event_in  (rx_data_in),
        .led_n_out (rx_led_n)
    );

    apfs_led_stretch u_any_led (
        .mclk_in   (mclk_in),
        .rst_b_in  (rst_b_in),
        .event_in  (tx_data_in | rx_data_in),
        .led_n_out (any_led_n)
    );

    // ========================================================================
    // GPIO slot count: the first four GPIO-assigned pins are honoured.
    // ========================================================================
    function automatic logic [PIN_CNT-1:0] gpio_grant(
        input logic [PIN_CNT*FUNC_W-1:0] f
    );
        logic [PIN_CNT-1:0] g;
        int unsigned        n;
        g = '0;
        n = 0;
        for (int i = 0; i < PIN_CNT; i++) begin
            if (apfs_func_t'(f[i*FUNC_W +: FUNC_W]) == APFS_FN_GPIO &&
                n < GPIO_CNT) begin
                g[i] = 1'b1;
                n    = n + 1;
            end
        end
        return g;
    endfunction : gpio_grant

    // ========================================================================
    // Per-pin output selection.
    // ========================================================================
    logic [PIN_CNT-1:0]         pin_ff;
    logic [PIN_CNT-1:0]         nxt_pin;
    logic [PIN_CNT-1:0]         oe_n_ff;
    logic [PIN_CNT-1:0]         nxt_oe_n;
    logic [PIN_CNT-1:0]         pu_ff;
    logic [PIN_CNT-1:0]         nxt_pu;
    logic [PIN_CNT-1:0]         gin_ff;
    logic [PIN_CNT-1:0]         nxt_gin;
    logic [PIN_CNT*DRIVE_W-1:0] drv_out_ff;
    logic [PIN_CNT-1:0]         grant;

    assign grant = gpio_grant(func_ff);

    generate
        for (genvar p = 0; p < PIN_CNT; p++) begin : g_pin
            logic sel;
            logic drive;
            always_comb begin
                sel   = 1'b1;
                drive = 1'b1;
                nxt_pu[p]  = 1'b0;
                nxt_gin[p] = 1'b0;
                case (apfs_func_t'(func_ff[p*FUNC_W +: FUNC_W]))
                    APFS_FN_RS485_DRIVER_ENABLE: begin
                        sel = tx_shifting_in;
                    end
                    APFS_FN_POWER_ENABLE_N: begin
                        sel = usb_suspend_in;
                    end
                    APFS_FN_TX_ACTIVITY_LED_N:  sel = tx_led_n;
                    APFS_FN_RX_ACTIVITY_LED_N:  sel = rx_led_n;
                    APFS_FN_ANY_ACTIVITY_LED_N: sel = any_led_n;
                    APFS_FN_SUSPEND_N: begin
                        sel = ~usb_suspend_in;
                    end
                    APFS_FN_CLOCK_OUT_30MHZ:  sel = div_clk_ff[0];
                    APFS_FN_CLOCK_OUT_15MHZ:  sel = div_clk_ff[1];
                    APFS_FN_CLOCK_OUT_7P5MHZ: sel = div_clk_ff[2];
                    APFS_FN_DRIVE_HIGH:       sel = 1'b1;
                    APFS_FN_DRIVE_LOW:        sel = 1'b0;
                    APFS_FN_GPIO: begin
                        sel        = gpio_out_val_in[p];
                        drive      = grant[p] & gpio_dir_out_in[p];
                        nxt_pu[p]  = ~drive;
                        nxt_gin[p] = grant[p] & aux_control_bus_in[p];
                    end
                    default: begin
                        drive     = 1'b0;
                        nxt_pu[p] = 1'b1;
                    end
                endcase
                nxt_pin[p]  = sel ^ inv_ff[p];
                nxt_oe_n[p] = ~drive;
            end
        end
    endgenerate

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_ff     <= PIN_RST;
            oe_n_ff    <= PIN_RST;
            pu_ff      <= PIN_RST;
            gin_ff     <= '0;
            drv_out_ff <= '0;
        end else begin
            pin_ff     <= nxt_pin;
            oe_n_ff    <= nxt_oe_n;
            pu_ff      <= nxt_pu;
            gin_ff     <= nxt_gin;
            drv_out_ff <= drv_ff;
        end
    end

    assign aux_control_bus_out      = pin_ff;
    assign aux_control_bus_oe_n_out = oe_n_ff;
    assign aux_pullup_en_out        = pu_ff;
    assign aux_drive_out            = drv_out_ff;
    assign gpio_in_val_out          = gin_ff;

endmodule : apfs_aux_pin_function_select

//--- design/apfs_pkg.sv
package apfs_pkg;

    // ========================================================================
    // Pin count and configuration field layout.
    // ========================================================================
    localparam int unsigned PIN_CNT      = 11;
    localparam int unsigned GPIO_CNT     = 4;
    localparam int unsigned FUNC_W       = 4;
    localparam int unsigned DRIVE_W      = 2;

    // ========================================================================
    // Pin function codes.
    // ========================================================================
    typedef enum logic [3:0] {
        APFS_FN_PULLED_UP_UNUSED_INPUT = 4'h0,
        APFS_FN_RS485_DRIVER_ENABLE    = 4'h1,
        APFS_FN_POWER_ENABLE_N         = 4'h2,
        APFS_FN_TX_ACTIVITY_LED_N      = 4'h3,
        APFS_FN_RX_ACTIVITY_LED_N      = 4'h4,
        APFS_FN_ANY_ACTIVITY_LED_N     = 4'h5,
        APFS_FN_SUSPEND_N              = 4'h6,
        APFS_FN_CLOCK_OUT_30MHZ        = 4'h7,
        APFS_FN_CLOCK_OUT_15MHZ        = 4'h8,
        APFS_FN_CLOCK_OUT_7P5MHZ       = 4'h9,
        APFS_FN_DRIVE_HIGH             = 4'ha,
        APFS_FN_DRIVE_LOW              = 4'hb,
        APFS_FN_GPIO                   = 4'hc
    } apfs_func_t;

    // ========================================================================
    // Clock division and LED stretch timing.
    // ========================================================================
    localparam int unsigned REF_CLK_MHZ    = 250;
    localparam int unsigned REF_CLK_HZ     = REF_CLK_MHZ * 1000000;
    localparam int unsigned CLOCK_OUT_30MHZ_HZ       = 30000000;
    localparam int unsigned CLOCK_OUT_15MHZ_HZ       = 15000000;
    localparam int unsigned CLK7P5_HZ      = 7500000;
    localparam int unsigned DIV_W          = 6;
    localparam logic [DIV_W-1:0] DIV30_HALF  =
        DIV_W'(REF_CLK_HZ / (2 * CLOCK_OUT_30MHZ_HZ));
    localparam logic [DIV_W-1:0] DIV15_HALF  =
        DIV_W'(REF_CLK_HZ / (2 * CLOCK_OUT_15MHZ_HZ));
    localparam logic [DIV_W-1:0] DIV7P5_HALF =
        DIV_W'(REF_CLK_HZ / (2 * CLK7P5_HZ));
    localparam int unsigned LED_PULSE_NS   = 50000;
    localparam int unsigned LED_PULSE_CYC  =
        (LED_PULSE_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int unsigned LED_CNT_W      = 14;

    // ========================================================================
    // Reset values.
    // ========================================================================
    localparam logic [PIN_CNT-1:0] PIN_RST = '1;

endpackage : apfs_pkg

//--- design/apfs_led_stretch.sv
`timescale 1ns/10ps
module apfs_led_stretch
    import apfs_pkg::*;
(
    // Clock and reset.
    input  wire logic mclk_in,
    input  wire logic rst_b_in,
    // Activity event and stretched output.
    input  wire logic event_in,
    output logic      led_n_out
);

    logic [LED_CNT_W-1:0] cnt_ff;
    logic [LED_CNT_W-1:0] nxt_cnt;
    logic                 led_n_ff;
    logic                 nxt_led_n;

    // ========================================================================
    // Pulse is restarted by each event and held for a fixed width.
    // ========================================================================
    always_comb begin
        nxt_cnt = cnt_ff;
        if (event_in) begin
            nxt_cnt = LED_CNT_W'(LED_PULSE_CYC);
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
        nxt_led_n = (nxt_cnt == '0);
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_ff   <= '0;
            led_n_ff <= 1'b1;
        end else begin
            cnt_ff   <= nxt_cnt;
            led_n_ff <= nxt_led_n;
        end
    end

    assign led_n_out = led_n_ff;

endmodule : apfs_led_stretch

//--- tb/apfs_chk_sva.sv
`timescale 1ns/10ps
module apfs_chk
    import apfs_pkg::*;
(
    // Clock and reset.
    input wire logic                      mclk_in,
    input wire logic                      rst_b_in,
    // Configuration and status.
    input wire logic                      cfg_valid_in,
    input wire logic [PIN_CNT*FUNC_W-1:0] cfg_func_in,
    input wire logic [PIN_CNT-1:0]        cfg_invert_in,
    input wire logic                      tx_shifting_in,
    input wire logic                      tx_data_in,
    input wire logic                      rx_data_in,
    input wire logic                      usb_suspend_in,
    input wire logic [PIN_CNT-1:0]        gpio_out_val_in,
    input wire logic [PIN_CNT-1:0]        gpio_dir_out_in,
    // Pins.
    input wire logic [PIN_CNT-1:0]        aux_control_bus_out,
    input wire logic [PIN_CNT-1:0]        aux_control_bus_oe_n_out,
    input wire logic [PIN_CNT-1:0]        aux_pullup_en_out
);
    // ========================================================================
    // Copy of the pin 0 configuration.
    // ========================================================================
    logic [3:0] fn_ff, nxt_fn;
    logic       inv_ff, nxt_inv;
    logic [4:0] age_ff, nxt_age;
    wire        p0 = aux_control_bus_out[0];
    wire        z0 = aux_control_bus_oe_n_out[0];
    always_comb begin
        nxt_fn  = cfg_valid_in ? cfg_func_in[3:0] : fn_ff;
        nxt_inv = cfg_valid_in ? cfg_invert_in[0] : inv_ff;
        nxt_age = (nxt_fn != fn_ff) ? 5'h00 : age_ff + {4'h0, age_ff != 5'h1f};
    end
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fn_ff  <= 4'h0;
            inv_ff <= 1'b0;
            age_ff <= 5'h00;
        end else begin
            fn_ff  <= nxt_fn;
            inv_ff <= nxt_inv;
            age_ff <= nxt_age;
        end
    end
    // ========================================================================
    // Assertions on pin 0.
    // ========================================================================
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    sequence led_lit;  !p0 [*8]; endsequence
    sequence half4;    p0 [*4] ##1 !p0; endsequence
    sequence half8;    p0 [*8] ##1 !p0; endsequence
    a_de_follows_tx: assert property (
        fn_ff == 4'h1 |=> p0 == $past(tx_shifting_in ^ inv_ff))
        else $error("driver enable wrong");
    a_pwr_en_suspend: assert property (
        fn_ff == 4'h2 |=> p0 == $past(usb_suspend_in ^ inv_ff))
        else $error("power enable wrong");
    a_suspend_ind_low: assert property (
        fn_ff == 4'h6 |=> p0 == $past(!usb_suspend_in ^ inv_ff))
        else $error("suspend indicator wrong");
    a_tx_led_pulse: assert property (
        fn_ff == 4'h3 && !inv_ff && tx_data_in |=> ##1 led_lit)
        else $error("transmit led wrong");
    a_rx_led_pulse: assert property (
        fn_ff == 4'h4 && !inv_ff && rx_data_in |=> ##1 led_lit)
        else $error("receive led wrong");
    a_any_led_pulse: assert property (
        fn_ff == 4'h5 && !inv_ff && (tx_data_in || rx_data_in) |=> ##1 led_lit)
        else $error("activity led wrong");
    a_clk_fast_half: assert property (
        disable iff (!rst_b_in || cfg_valid_in)
        fn_ff == 4'h7 && age_ff == 5'h1f && $rose(p0) |-> half4)
        else $error("fast clock phase wrong");
    a_clk_mid_half: assert property (
        disable iff (!rst_b_in || cfg_valid_in)
        fn_ff == 4'h8 && age_ff == 5'h1f && $rose(p0) |-> half8)
        else $error("middle clock phase wrong");
    a_unused_released: assert property (
        fn_ff == 4'h0 |=> z0 && aux_pullup_en_out[0])
        else $error("unused pin driven");
    a_const_high_out: assert property (
        fn_ff == 4'ha |=> !z0 && p0 == !$past(inv_ff))
        else $error("constant high wrong");
    a_gpio_lowest_pin: assert property (
        fn_ff == 4'hc && !inv_ff |=> z0 != $past(gpio_dir_out_in[0])
        && (z0 || p0 == $past(gpio_out_val_in[0])))
        else $error("gpio pin wrong");
endmodule : apfs_chk

bind apfs_aux_pin_function_select apfs_chk u_apfs_chk (
    .mclk_in                  (mclk_in),
    .rst_b_in                 (rst_b_in),
    .cfg_valid_in             (cfg_valid_in),
    .cfg_func_in              (cfg_func_in),
    .cfg_invert_in            (cfg_invert_in),
    .tx_shifting_in           (tx_shifting_in),
    .tx_data_in               (tx_data_in),
    .rx_data_in               (rx_data_in),
    .usb_suspend_in           (usb_suspend_in),
    .gpio_out_val_in          (gpio_out_val_in),
    .gpio_dir_out_in          (gpio_dir_out_in),
    .aux_control_bus_out      (aux_control_bus_out),
    .aux_control_bus_oe_n_out (aux_control_bus_oe_n_out),
    .aux_pullup_en_out        (aux_pullup_en_out)
);

//--- tb/apfs_board.sv
`timescale 1ns/10ps
module apfs_board
    import apfs_pkg::*;
(
    // Clock.
    input  wire logic               mclk_in,
    // Pin drivers of the block and of the board.
    input  wire logic [PIN_CNT-1:0] pin_out_in,
    input  wire logic [PIN_CNT-1:0] oe_n_in,
    input  wire logic [PIN_CNT-1:0] pullup_in,
    input  wire logic [PIN_CNT-1:0] ext_en_in,
    input  wire logic [PIN_CNT-1:0] ext_val_in,
    // Resolved pin level.
    output logic      [PIN_CNT-1:0] lvl_out
);
    logic [PIN_CNT-1:0] last_ff;
    // A released pin without pull-up or board driver drifts away.
    assign lvl_out = (~oe_n_in & pin_out_in)
                   | (oe_n_in & ext_en_in & ext_val_in)
                   | (oe_n_in & ~ext_en_in & (pullup_in | ~last_ff));
    always_ff @(posedge mclk_in) begin
        last_ff <= lvl_out;
    end
endmodule : apfs_board

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import apfs_pkg::*;
;
    logic mclk_in, rst_b_in, cfg_valid_in, tx_shifting_in;
    logic tx_data_in, rx_data_in, usb_suspend_in;
    logic [PIN_CNT*FUNC_W-1:0]  cfg_func_in;
    logic [PIN_CNT*DRIVE_W-1:0] cfg_drive_in, aux_drive_out;
    logic [PIN_CNT-1:0] cfg_invert_in, gpio_out_val_in, gpio_dir_out_in;
    logic [PIN_CNT-1:0] gpio_in_val_out, aux_control_bus_in, ext_en, ext_val;
    logic [PIN_CNT-1:0] aux_control_bus_out, aux_control_bus_oe_n_out;
    logic [PIN_CNT-1:0] aux_pullup_en_out, iv;
    logic [3:0]         codes [5] = '{4'h1, 4'h2, 4'h6, 4'ha, 4'hb};
    logic [DIV_W-1:0]   hv [3] = '{DIV30_HALF, DIV15_HALF, DIV7P5_HALF};
    logic               e, prv;
    int                 fail_count, check_count, n, h;
    apfs_aux_pin_function_select u_apfs_aux_pin_function_select (
        .mclk_in                  (mclk_in),
        .rst_b_in                 (rst_b_in),
        .cfg_valid_in             (cfg_valid_in),
        .cfg_func_in              (cfg_func_in),
        .cfg_invert_in            (cfg_invert_in),
        .cfg_drive_in             (cfg_drive_in),
        .tx_shifting_in           (tx_shifting_in),
        .tx_data_in               (tx_data_in),
        .rx_data_in               (rx_data_in),
        .usb_suspend_in           (usb_suspend_in),
        .gpio_out_val_in          (gpio_out_val_in),
        .gpio_dir_out_in          (gpio_dir_out_in),
        .gpio_in_val_out          (gpio_in_val_out),
        .aux_control_bus_in       (aux_control_bus_in),
        .aux_control_bus_out      (aux_control_bus_out),
        .aux_control_bus_oe_n_out (aux_control_bus_oe_n_out),
        .aux_pullup_en_out        (aux_pullup_en_out),
        .aux_drive_out            (aux_drive_out)
    );
    apfs_board u_apfs_board (
        .mclk_in    (mclk_in),
        .pin_out_in (aux_control_bus_out),
        .oe_n_in    (aux_control_bus_oe_n_out),
        .pullup_in  (aux_pullup_en_out),
        .ext_en_in  (ext_en),
        .ext_val_in (ext_val),
        .lvl_out    (aux_control_bus_in)
    );
    // ========================================================================
    // Access and compare tasks.
    // ========================================================================
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    task automatic step(input int c);
        repeat (c) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask : step
    task automatic tally(input bit ok);
        check_count++;
        if (!ok) begin
            fail_count++;
            $display("[FAIL] %0t pin value mismatch", $time);
        end
    endtask : tally
    task automatic chk(input logic [PIN_CNT-1:0] g,
                       input logic [PIN_CNT-1:0] x);
        tally(g === x);
    endtask : chk
    task automatic chk_drv(input logic [PIN_CNT*DRIVE_W-1:0] g, x);
        tally(g === x);
    endtask : chk_drv
    task automatic chk_cnt(input int g, input int lo, input int hi);
        tally(g >= lo && g <= hi);
    endtask : chk_cnt
    task automatic load(input logic [3:0] c, input logic [PIN_CNT-1:0] v);
        @(posedge mclk_in);
        cfg_func_in   <= {PIN_CNT{c}};
        cfg_invert_in <= v;
        cfg_drive_in  <= {PIN_CNT{c[1:0]}};
        cfg_valid_in  <= 1'b1;
        @(posedge mclk_in);
        cfg_valid_in  <= 1'b0;
        step(3);
    endtask : load
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (100000) @(posedge mclk_in);
        fail_count++;
        conclude();
    end
    // ========================================================================
    // Tests.
    // ========================================================================
    initial begin
        {rst_b_in, cfg_valid_in, tx_shifting_in, tx_data_in} = 4'h0;
        {rx_data_in, usb_suspend_in, cfg_func_in, cfg_drive_in} = '0;
        {cfg_invert_in, gpio_out_val_in, gpio_dir_out_in, ext_en} = '0;
        ext_val = '0;
        repeat (8) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        step(1);
        chk(aux_control_bus_oe_n_out & aux_pullup_en_out, 11'h7ff);
        chk_drv(aux_drive_out, '0);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 5; k++) begin
                iv = p ? 11'h5a3 : 11'h000;
                load(codes[k], iv);
                chk_drv(aux_drive_out, {PIN_CNT{codes[k][1:0]}});
                chk(aux_control_bus_oe_n_out, 11'h000);
                for (int s = 0; s < 4; s++) begin
                    @(posedge mclk_in);
                    tx_shifting_in <= s[0];
                    usb_suspend_in <= s[1];
                    step(2);
                    case (codes[k])
                        4'h1: e = s[0];
                        4'h2: e = s[1];
                        4'h6: e = !s[1];
                        4'ha: e = 1'b1;
                        default: e = 1'b0;
                    endcase
                    chk(aux_control_bus_out,
                        {PIN_CNT{e}} ^ iv);
                end
            end
        end
        for (int c = 3; c < 6; c++) begin
            for (int ev = 0; ev < 2; ev++) begin
                load(4'(c), 11'h000);
                @(posedge mclk_in);
                tx_data_in <= (ev == 0);
                rx_data_in <= (ev == 1);
                @(posedge mclk_in);
                tx_data_in <= 1'b0;
                rx_data_in <= 1'b0;
                e = (c == 5) || (c == 3 && ev == 0) || (c == 4 && ev == 1);
                step(LED_PULSE_CYC - 8);
                chk(aux_control_bus_out,
                    e ? 11'h000 : 11'h7ff);
                step(16);
                chk(aux_control_bus_out, 11'h7ff);
            end
        end
        for (int k = 0; k < 3; k++) begin
            load(4'(7 + k), 11'h000);
            step(40);
            n = 0;
            prv = aux_control_bus_out[0];
            h = int'(hv[k]);
            repeat (512) begin
                step(1);
                n += (aux_control_bus_out[0] && !prv);
                prv = aux_control_bus_out[0];
            end
            chk_cnt(n, 512 / (2 * h) - 1, 512 / (2 * h) + 1);
        end
        load(4'hc, 11'h000);
        @(posedge mclk_in);
        gpio_dir_out_in <= 11'h7fd;
        gpio_out_val_in <= 11'h005;
        ext_en <= 11'h002;
        ext_val <= 11'h002;
        step(3);
        chk(aux_control_bus_oe_n_out, 11'h7f2);
        chk(aux_control_bus_out & 11'h00d, 11'h005);
        chk(aux_pullup_en_out & 11'h7f0, 11'h7f0);
        chk(gpio_in_val_out, 11'h007);
        @(posedge mclk_in);
        ext_en <= 11'h000;
        for (int k = 0; k < 2; k++) begin
            load(k ? 4'he : 4'h0, 11'h7ff);
            chk(aux_control_bus_oe_n_out & aux_pullup_en_out, 11'h7ff);
            chk(aux_control_bus_in, 11'h7ff);
            chk(gpio_in_val_out, 11'h000);
        end
        @(posedge mclk_in);
        cfg_func_in <= {PIN_CNT{4'ha}};
        step(3);
        chk(aux_control_bus_oe_n_out, 11'h7ff);
        conclude();
    end
endmodule : tb_top
